// ---- sbsr_pkg.sv ----
// Constants, carriers and states for the status byte and service request block.
// Assumes one 25 MHz clock shared with the command parser that drives it.
// What this block does
// - Message-available bit 4 follows output buffer data presence with no latch.
// - Summary bits are unlatched and track their source conditions continuously.
// - Clearing one event register clears only its own summary bit.
// - Message-available drops after every queued message has been read, and while a fetch is in progress.
// - Bit 3 is set when any enabled questionable event bit is set.
// - Bit 5 is set when any enabled standard event bit is set.
// - Bit 6 means requesting service; bits 0, 1, 2 and 7 read zero.
// - Clear-status clears the summary and all event registers.
// - Service enable clears on a write of zero, or at power-on after flag 1.
// - Power-on keeps the service enable when the power-on flag was 0.
// - Enabled summary bits rising from none set request-service and drive the SRQ line.
// - Serial poll, or reading the causing event register, clears the request.
// - Serial poll clears only the request bit and never stalls measurement.
// - Register queries return the binary weighted sum of set bits.
// - Status byte query matches serial poll except bit 6, which shows the live service summary; it never clears the request.
// - Status byte query runs in order, after earlier commands complete.
// - Status byte query clears no bit of the summary register.
// - With immediate trigger, message-available sets on the first reading.
// - With stored readings, message-available waits until the fetch has moved all.
// - Operation-complete bit 0 sets once the operation-complete command executes.

package sbsr_pkg;

   localparam int              STB_QSB_BIT     = 3;
   localparam int              STB_MAV_BIT     = 4;
   localparam int              STB_ESB_BIT     = 5;
   localparam int              STB_RQS_BIT     = 6;
   localparam logic [7:0]      STB_UNUSED_MASK = 8'h87;
   localparam logic [7:0]      SRE_SVC_MASK    = 8'h38;
   localparam logic [7:0]      SRE_WRITE_MASK  = 8'hBF;
   localparam int              ESR_OPC_BIT     = 0;
   localparam int              ESR_PON_BIT     = 7;
   localparam logic [7:0]      ESR_USED_MASK   = 8'hBD;
   localparam logic [15:0]     QUES_USED_MASK  = 16'h1A03;
   localparam logic [7:0]      EVENT8_RST      = 8'h00;
   localparam logic [15:0]     EVENT16_RST     = 16'h0000;
   localparam logic [7:0]      ENABLE8_RST     = 8'h00;
   localparam logic [15:0]     ENABLE16_RST    = 16'h0000;
   localparam logic [15:0]     RESP_RST        = 16'h0000;
   localparam logic            PSC_RST         = 1'b1;

   typedef struct packed {
      logic       unused_hi;
      logic       rqs;
      logic       esb;
      logic       mav;
      logic       qsb;
      logic [2:0] unused_lo;
   } sbsr_status_t;

   typedef struct packed {
      logic clear_status;
      logic ese_write;
      logic sre_write;
      logic ques_en_write;
      logic ques_preset;
      logic psc_write;
      logic esr_query;
      logic ese_query;
      logic sre_query;
      logic ques_event_query;
      logic ques_en_query;
      logic stb_query;
   } sbsr_cmd_t;

   typedef enum logic {
      SBSR_STBQ_IDLE,
      SBSR_STBQ_WAIT
   } sbsr_stbq_t;

endpackage : sbsr_pkg

// ---- sbsr_status_byte.sv ----
// Status byte summary, service request and register query answers.
// Assumes command strobes, event pulses and buffer flags come from logic on clock.
`timescale 1ns/100ps

module sbsr_status_byte
(
   input  wire logic                clock,
   input  wire logic                rst_n,
   input  wire sbsr_pkg::sbsr_cmd_t cmd,
   input  wire logic [15:0]         wr_data,
   input  wire logic                cmd_busy,
   input  wire logic                psc_stored,
   input  wire logic [7:0]          ese_stored,
   input  wire logic [7:0]          sre_stored,
   input  wire logic [7:0]          std_event_set,
   input  wire logic [15:0]         ques_event_set,
   input  wire logic                opc_executed,
   input  wire logic                out_buf_pending,
   input  wire logic                fetch_in_progress,
   input  wire logic                serial_poll,
   output logic                     spoll_valid,
   output logic [7:0]               spoll_byte,
   output logic                     resp_valid,
   output logic [15:0]              resp_data,
   output sbsr_pkg::sbsr_status_t   status_byte,
   output logic                     srq,
   output logic                     psc_flag,
   output logic [7:0]               ese_value,
   output logic [7:0]               sre_value,
   output logic [15:0]              ques_enable
);

   logic                 load_pending;
   logic [7:0]           std_event;
   logic [15:0]          ques_event;
   logic                 rqs;
   logic                 svc_prev;
   logic [7:0]           rqs_cause;
   sbsr_pkg::sbsr_stbq_t stbq_state;
   sbsr_pkg::sbsr_stbq_t next_stbq_state;

   wire        mav;
   wire        qsb;
   wire        esb;
   wire [7:0]  summary_raw;
   wire [7:0]  svc_bits;
   wire        svc_cond;
   wire        svc_rise;
   wire        std_clear;
   wire        ques_clear;
   wire [7:0]  std_set_all;
   wire [7:0]  next_std_event;
   wire [15:0] next_ques_event;
   wire        rqs_clear;
   wire        next_rqs;
   wire [7:0]  next_rqs_cause;
   wire        stb_fire;
   wire        stbq_idle;
   wire [7:0]  stb_answer;
   wire        other_query;
   wire [15:0] query_answer;

   // Fetch gating keeps stored readings invisible until the transfer is whole
   assign mav = out_buf_pending & ~fetch_in_progress;
   assign qsb = |(ques_event & ques_enable);
   assign esb = |(std_event & ese_value);

   assign status_byte.unused_hi = 1'b0;
   assign status_byte.rqs       = rqs;
   assign status_byte.esb       = esb;
   assign status_byte.mav       = mav;
   assign status_byte.qsb       = qsb;
   assign status_byte.unused_lo = 3'b000;

   assign summary_raw = {2'b00, esb, mav, qsb, 3'b000};
   assign svc_bits    = summary_raw & sre_value & sbsr_pkg::SRE_SVC_MASK;
   assign svc_cond    = |svc_bits;
   // Edge-triggered so a poll cannot be followed by an instant re-request
   assign svc_rise    = svc_cond & ~svc_prev;

   assign std_clear   = cmd.clear_status | cmd.esr_query;
   assign ques_clear  = cmd.clear_status | cmd.ques_event_query;
   assign std_set_all = std_event_set
                      | {7'b000_0000, opc_executed}
                      | {load_pending, 7'b000_0000};
   // Set is ORed after the clear so an arriving event is never lost
   assign next_std_event  = (std_event & ~{8{std_clear}})
                          | (std_set_all & sbsr_pkg::ESR_USED_MASK);
   assign next_ques_event = (ques_event & ~{16{ques_clear}})
                          | (ques_event_set & sbsr_pkg::QUES_USED_MASK);

   assign rqs_clear = serial_poll
                    | cmd.clear_status
                    | (cmd.esr_query & rqs_cause[sbsr_pkg::STB_ESB_BIT])
                    | (cmd.ques_event_query & rqs_cause[sbsr_pkg::STB_QSB_BIT]);
   assign next_rqs       = svc_rise | (rqs & ~rqs_clear);
   assign next_rqs_cause = svc_rise ? svc_bits : rqs_cause;

   assign stbq_idle  = (stbq_state == sbsr_pkg::SBSR_STBQ_IDLE);
   assign stb_fire   = ~cmd_busy & (stbq_idle ? cmd.stb_query : 1'b1);
   // Bit 6 carries the live service summary, untouched by a poll
   assign stb_answer = {1'b0, svc_cond, summary_raw[5:0]};

   // A pending status byte query holds the answer port; other queries meanwhile are dropped
   assign other_query = stbq_idle & ~cmd.stb_query
                      & (cmd.esr_query | cmd.ese_query | cmd.sre_query
                         | cmd.ques_event_query | cmd.ques_en_query);
   assign query_answer = cmd.esr_query        ? {8'h00, std_event}
                       : cmd.ese_query        ? {8'h00, ese_value}
                       : cmd.sre_query        ? {8'h00, sre_value}
                       : cmd.ques_event_query ? ques_event
                       : ques_enable;

   always_comb
   begin
      next_stbq_state = stbq_state;
      unique case (stbq_state)
         sbsr_pkg::SBSR_STBQ_IDLE:
         begin
            if (cmd.stb_query && cmd_busy)
            begin
               next_stbq_state = sbsr_pkg::SBSR_STBQ_WAIT;
            end
         end
         sbsr_pkg::SBSR_STBQ_WAIT:
         begin
            if (!cmd_busy)
            begin
               next_stbq_state = sbsr_pkg::SBSR_STBQ_IDLE;
            end
         end
      endcase
   end

   // Power-on load runs one cycle after release so the stored flag is sampled
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         load_pending <= 1'b1;
         psc_flag     <= sbsr_pkg::PSC_RST;
      end
      else
      begin
         load_pending <= 1'b0;
         if (load_pending)
         begin
            psc_flag <= psc_stored;
         end
         else if (cmd.psc_write)
         begin
            psc_flag <= wr_data[0];
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ese_value   <= sbsr_pkg::ENABLE8_RST;
         sre_value   <= sbsr_pkg::ENABLE8_RST;
         ques_enable <= sbsr_pkg::ENABLE16_RST;
      end
      else if (load_pending)
      begin
         ese_value <= psc_stored ? sbsr_pkg::ENABLE8_RST : ese_stored;
         sre_value <= psc_stored ? sbsr_pkg::ENABLE8_RST
                                 : (sre_stored & sbsr_pkg::SRE_WRITE_MASK);
      end
      else
      begin
         if (cmd.ese_write)
         begin
            ese_value <= wr_data[7:0];
         end
         if (cmd.sre_write)
         begin
            sre_value <= wr_data[7:0] & sbsr_pkg::SRE_WRITE_MASK;
         end
         if (cmd.ques_preset)
         begin
            ques_enable <= sbsr_pkg::ENABLE16_RST;
         end
         else if (cmd.ques_en_write)
         begin
            ques_enable <= wr_data;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         std_event  <= sbsr_pkg::EVENT8_RST;
         ques_event <= sbsr_pkg::EVENT16_RST;
      end
      else
      begin
         std_event  <= next_std_event;
         ques_event <= next_ques_event;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rqs       <= 1'b0;
         svc_prev  <= 1'b0;
         rqs_cause <= sbsr_pkg::EVENT8_RST;
         srq       <= 1'b0;
      end
      else
      begin
         rqs       <= next_rqs;
         svc_prev  <= svc_cond;
         rqs_cause <= next_rqs_cause;
         srq       <= next_rqs;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stbq_state  <= sbsr_pkg::SBSR_STBQ_IDLE;
         resp_valid  <= 1'b0;
         resp_data   <= sbsr_pkg::RESP_RST;
         spoll_valid <= 1'b0;
         spoll_byte  <= sbsr_pkg::EVENT8_RST;
      end
      else
      begin
         stbq_state  <= next_stbq_state;
         resp_valid  <= stb_fire | other_query;
         spoll_valid <= serial_poll;
         if (stb_fire)
         begin
            resp_data <= {8'h00, stb_answer};
         end
         else if (other_query)
         begin
            resp_data <= query_answer;
         end
         if (serial_poll)
         begin
            spoll_byte <= status_byte;
         end
      end
   end

   sequence esr_ask_s;
      cmd.esr_query && stbq_idle && !cmd.stb_query;
   endsequence

   sequence esr_answer_s;
      resp_valid && (resp_data == {8'h00, $past(std_event)});
   endsequence

   sequence stb_blocked_s;
      stbq_idle && cmd.stb_query && cmd_busy;
   endsequence

   sequence stb_go_s;
      !cmd_busy && (cmd.stb_query || !stbq_idle);
   endsequence

   mav_direct_a: assert property (@(posedge clock) disable iff (!rst_n)
      (out_buf_pending && !fetch_in_progress) |-> status_byte.mav)
      else $error("Message available not shown for pending data");

   mav_fetch_a: assert property (@(posedge clock) disable iff (!rst_n)
      fetch_in_progress |-> !status_byte.mav)
      else $error("Message available shown during fetch");

   unused_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
      (status_byte & sbsr_pkg::STB_UNUSED_MASK) == 8'h00)
      else $error("Unused status byte bit set");

   qsb_summary_a: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(|(ques_event & ques_enable)) |-> status_byte.qsb)
      else $error("Questionable summary missed");

   esb_summary_a: assert property (@(posedge clock) disable iff (!rst_n)
      (std_event_set[5] && ese_value[5] && !cmd.ese_write && !load_pending) |=> status_byte.esb)
      else $error("Standard event summary missed");

   rqs_set_a: assert property (@(posedge clock) disable iff (!rst_n)
      svc_rise |=> (rqs && srq))
      else $error("Service request not raised");

   srq_follow_a: assert property (@(posedge clock) disable iff (!rst_n)
      srq == status_byte.rqs)
      else $error("SRQ differs from request bit");

   spoll_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
      (serial_poll && !svc_rise) |=> !rqs)
      else $error("Serial poll left request set");

   spoll_byte_a: assert property (@(posedge clock) disable iff (!rst_n)
      serial_poll |=> (spoll_valid && spoll_byte == $past(status_byte)))
      else $error("Serial poll byte wrong");

   cls_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
      (cmd.clear_status && !svc_rise && std_set_all == 8'h00 && ques_event_set == 16'h0000)
      |=> (std_event == 8'h00 && ques_event == 16'h0000 && !rqs))
      else $error("Clear status left bits set");

   esr_query_a: assert property (@(posedge clock) disable iff (!rst_n)
      esr_ask_s |=> esr_answer_s)
      else $error("Standard event query answer wrong");

   stb_order_a: assert property (@(posedge clock) disable iff (!rst_n)
      stb_blocked_s |=> !resp_valid)
      else $error("Status byte query answered while busy");

   opc_set_a: assert property (@(posedge clock) disable iff (!rst_n)
      opc_executed |=> std_event[sbsr_pkg::ESR_OPC_BIT])
      else $error("Operation complete not recorded");

   stb_answer_a: assert property (@(posedge clock) disable iff (!rst_n)
      stb_go_s |=> (resp_valid && resp_data
         == {8'h00, 1'b0, $past(svc_cond), $past(status_byte[5:0])}))
      else $error("Status byte query answer wrong");

   stb_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
      (cmd.stb_query && !rqs_clear && !svc_rise) |=> (rqs == $past(rqs)))
      else $error("Status byte query changed request bit");

   cause_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
      (cmd.ques_event_query && rqs_cause[sbsr_pkg::STB_QSB_BIT] && !svc_rise)
      |=> (!rqs && !srq))
      else $error("Request kept after reading its cause");

   // Sampled reset skips the release edge, where the flops are still held
   pon_enable_a: assert property (@(posedge clock) disable iff (!rst_n)
      (load_pending && rst_n) |=> (sre_value == ($past(psc_stored) ? sbsr_pkg::ENABLE8_RST
         : ($past(sre_stored) & sbsr_pkg::SRE_WRITE_MASK))))
      else $error("Service enable not restored at power-on");

   sre_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
      (cmd.sre_write && wr_data[7:0] == 8'h00 && !load_pending) |=> (sre_value == 8'h00))
      else $error("Service enable not cleared by zero write");

endmodule : sbsr_status_byte

// ---- sbsr_host_model.sv ----
// Bus controller model: answers an asserted SRQ with one serial poll.
// Assumes the device pulses spoll_valid one cycle after it takes a poll.
`timescale 1ns/100ps

module sbsr_host_model
(
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       irq_en,
   input  wire logic       srq,
   input  wire logic       spoll_valid,
   input  wire logic [7:0] spoll_byte,
   output logic            serial_poll,
   output logic [7:0]      poll_byte,
   output logic [7:0]      poll_count
);
   logic waiting;
   // Interrupt honoured only once enabled, the last set-up step
   wire  start = !waiting && !serial_poll && irq_en && srq;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         serial_poll <= 1'b0;
         waiting     <= 1'b0;
         poll_byte   <= 8'h00;
         poll_count  <= 8'h00;
      end
      else
      begin
         serial_poll <= start;
         if (start)
            waiting <= 1'b1;
         else if (waiting && spoll_valid)
         begin
            waiting    <= 1'b0;
            poll_byte  <= spoll_byte;
            poll_count <= poll_count + 8'h01;
         end
      end
   end
endmodule : sbsr_host_model

// ---- testbench.sv ----
// Self-checking bench for the status byte and service request block.
// Assumes the host model polls on SRQ while irq_en is set.
`timescale 1ns/100ps

module testbench;
   localparam int c_cls   = 11;
   localparam int c_ese_w = 10;
   localparam int c_sre_w = 9;
   localparam int c_qen_w = 8;
   localparam int c_esr_q = 5;
   localparam int c_qev_q = 2;
   localparam int c_stb_q = 0;
   localparam int c_qen_q = 1;
   localparam int c_sre_q = 3;
   localparam int c_ese_q = 4;
   localparam int c_psc_w = 6;
   localparam int c_pre   = 7;

   logic                   clock             = 1'b0;
   logic                   rst_n             = 1'b0;
   sbsr_pkg::sbsr_cmd_t    cmd               = '0;
   logic [15:0]            wr_data           = 16'h0000;
   logic                   cmd_busy          = 1'b0;
   logic                   psc_stored        = 1'b0;
   logic [7:0]             ese_stored        = 8'h80;
   logic [7:0]             sre_stored        = 8'h10;
   logic [7:0]             std_event_set     = 8'h00;
   logic [15:0]            ques_event_set    = 16'h0000;
   logic                   opc_executed      = 1'b0;
   logic                   out_buf_pending   = 1'b0;
   logic                   fetch_in_progress = 1'b0;
   logic                   irq_en            = 1'b0;
   logic                   serial_poll;
   logic                   spoll_valid;
   logic [7:0]             spoll_byte;
   logic                   resp_valid;
   logic [15:0]            resp_data;
   sbsr_pkg::sbsr_status_t status_byte;
   logic                   srq;
   logic                   psc_flag;
   logic [7:0]             ese_value;
   logic [7:0]             sre_value;
   logic [15:0]            ques_enable;
   logic [7:0]             poll_byte;
   logic [7:0]             poll_count;
   int                     err_count         = 0;
   int                     tests_run         = 0;

   sbsr_status_byte i_dut (.clock(clock), .rst_n(rst_n), .cmd(cmd), .wr_data(wr_data),
      .cmd_busy(cmd_busy), .psc_stored(psc_stored), .ese_stored(ese_stored),
      .sre_stored(sre_stored), .std_event_set(std_event_set),
      .ques_event_set(ques_event_set), .opc_executed(opc_executed),
      .out_buf_pending(out_buf_pending), .fetch_in_progress(fetch_in_progress),
      .serial_poll(serial_poll), .spoll_valid(spoll_valid), .spoll_byte(spoll_byte),
      .resp_valid(resp_valid), .resp_data(resp_data), .status_byte(status_byte),
      .srq(srq), .psc_flag(psc_flag), .ese_value(ese_value), .sre_value(sre_value),
      .ques_enable(ques_enable));

   sbsr_host_model i_host (.clock(clock), .rst_n(rst_n), .irq_en(irq_en), .srq(srq),
      .spoll_valid(spoll_valid), .spoll_byte(spoll_byte), .serial_poll(serial_poll),
      .poll_byte(poll_byte), .poll_count(poll_count));

   initial
   begin
      forever #20 clock = ~clock;
   end

   task automatic end_sim;
      $display("checks run %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp)
      begin
         err_count = err_count + 1;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick

   // Strobe is taken at the second edge; answers are read just after it
   task automatic send(input int idx, input logic [15:0] d);
      @(posedge clock);
      cmd     <= sbsr_pkg::sbsr_cmd_t'(12'h001 << idx);
      wr_data <= d;
      @(posedge clock);
      cmd <= '0;
      #1;
   endtask : send

   task automatic query(input int idx, input logic [15:0] exp);
      send(idx, 16'h0000);
      check(16'(resp_valid), 16'h0001);
      check(resp_data, exp);
   endtask : query

   task automatic ev(input logic [7:0] s, input logic [15:0] q, input logic o);
      @(posedge clock);
      std_event_set  <= s;
      ques_event_set <= q;
      opc_executed   <= o;
      @(posedge clock);
      std_event_set  <= 8'h00;
      ques_event_set <= 16'h0000;
      opc_executed   <= 1'b0;
      #1;
   endtask : ev

   task automatic mav(input logic p, input logic f, input logic exp);
      @(posedge clock);
      out_buf_pending   <= p;
      fetch_in_progress <= f;
      #1;
      check(16'(status_byte.mav), 16'(exp));
   endtask : mav

   // Writes are ignored in the load cycle, so two edges pass after release
   task automatic do_reset(input logic p);
      @(posedge clock);
      rst_n      <= 1'b0;
      psc_stored <= p;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      tick(2);
   endtask : do_reset

   initial
   begin
      do_reset(1'b0);
      check(16'(sre_value), 16'h0010);
      check(16'(ese_value), 16'h0080);
      check(16'(status_byte), 16'h0020);
      query(c_esr_q, 16'h0080);
      check(16'(status_byte), 16'h0000);
      send(c_cls, 16'h0000);
      send(c_ese_w, 16'h0001);
      send(c_sre_w, 16'h0020);
      @(posedge clock) irq_en <= 1'b1;
      ev(8'h00, 16'h0000, 1'b1);
      check(16'(status_byte), 16'h0020);
      for (int i = 0; i < 20 && poll_count === 8'h00; i++)
         tick(1);
      check(16'(poll_byte), 16'h0060);
      check(16'(srq), 16'h0000);
      check(16'(status_byte), 16'h0020);
      query(c_stb_q, 16'h0060);
      check(16'(status_byte), 16'h0020);
      @(posedge clock) irq_en <= 1'b0;
      query(c_esr_q, 16'h0001);
      send(c_ese_w, 16'h0020);
      send(c_sre_w, 16'h0008);
      send(c_qen_w, 16'h1a03);
      check(ques_enable, 16'h1a03);
      query(c_qen_q, 16'h1a03);
      query(c_ese_q, 16'h0020);
      query(c_sre_q, 16'h0008);
      ev(8'h20, 16'hffff, 1'b0);
      tick(1);
      check(16'(status_byte), 16'h0068);
      check(16'(srq), 16'h0001);
      query(c_qev_q, 16'h1a03);
      check(16'(status_byte), 16'h0020);
      check(16'(srq), 16'h0000);
      mav(1'b1, 1'b0, 1'b1);
      mav(1'b1, 1'b1, 1'b0);
      mav(1'b1, 1'b0, 1'b1);
      mav(1'b0, 1'b0, 1'b0);
      @(posedge clock) cmd_busy <= 1'b1;
      send(c_stb_q, 16'h0000);
      tick(3);
      check(16'(resp_valid), 16'h0000);
      @(posedge clock) cmd_busy <= 1'b0;
      tick(1);
      for (int i = 0; i < 10 && resp_valid !== 1'b1; i++)
         tick(1);
      check(16'(resp_valid), 16'h0001);
      check(resp_data, 16'h0020);
      send(c_cls, 16'h0000);
      check(16'(status_byte), 16'h0000);
      query(c_esr_q, 16'h0000);
      send(c_sre_w, 16'h00ff);
      check(16'(sre_value), 16'h00bf);
      send(c_pre, 16'h0000);
      check(ques_enable, 16'h0000);
      send(c_psc_w, 16'h0000);
      check(16'(psc_flag), 16'h0000);
      do_reset(1'b1);
      check(16'(sre_value), 16'h0000);
      check(16'(psc_flag), 16'h0001);
      send(c_sre_w, 16'h0020);
      send(c_sre_w, 16'h0000);
      check(16'(sre_value), 16'h0000);
      end_sim;
   end

   // Whole sequence needs well under a thousand cycles
   initial
   begin
      repeat (3000) @(posedge clock);
      err_count = err_count + 1;
      end_sim;
   end
endmodule : testbench
